// ==== design/pvbc_pkg.sv ====
// package: register map, field layout, reset values and timing for the pll band control block
package pvbc_pkg;
    // register offsets
    localparam logic [7:0] PVBC_ADDR_CTRL   = 8'h12;  // pll_control
    localparam logic [7:0] PVBC_ADDR_LOOP   = 8'h14;  // pll_loop_config
    localparam logic [7:0] PVBC_ADDR_DIV    = 8'h15;  // pll_divider_config
    localparam logic [7:0] PVBC_ADDR_STATUS = 8'h16;  // pll status, read only
    // reset values
    localparam logic [7:0] PVBC_CTRL_RST    = 8'h00;  // pll off, automatic, band 0
    localparam logic [7:0] PVBC_LOOP_RST    = 8'he7;  // bandwidth 111, pump 00111
    localparam logic [7:0] PVBC_DIV_RST     = 8'h00;  // divide ratios at minimum
    // pll_control fields
    localparam int PVBC_CTRL_EN     = 7;  // pll enable
    localparam int PVBC_CTRL_MANUAL = 6;  // 1 manual band, 0 automatic
    localparam int PVBC_BAND_W      = 6;  // band code width, 64 bands
    // pll_loop_config fields
    localparam int PVBC_BW_LSB      = 5;  // loop bandwidth [7:5]
    localparam int PVBC_BW_W        = 3;
    localparam int PVBC_CP_LSB      = 0;  // charge pump current [4:0]
    localparam int PVBC_CP_W        = 5;
    // pll_divider_config fields
    localparam int PVBC_LDIV_LSB    = 0;  // loop divide code [1:0]
    localparam int PVBC_VDIV_LSB    = 2;  // vco divide code [3:2]
    localparam int PVBC_DIV_CODE_W  = 2;
    localparam int PVBC_XPT_BIT     = 4;  // cross point control enable
    // status fields
    localparam int PVBC_ST_LOCK     = 7;  // pll lock
    localparam int PVBC_ST_BUSY     = 0;  // band search running
    // band search
    localparam logic [5:0] PVBC_BAND_MID = 6'h20;  // first trial of the search
    localparam int PVBC_CLK_NS      = 25;     // clk_sys period
    localparam int PVBC_SETTLE_NS   = 10000;  // least loop settle per search step
    localparam int PVBC_SETTLE_CYC  = (PVBC_SETTLE_NS + PVBC_CLK_NS - 1) / PVBC_CLK_NS;
    // search states
    typedef enum logic [0:0] {
        PVBC_S_IDLE   = 1'b0,
        PVBC_S_SETTLE = 1'b1
    } pvbc_state_t;
endpackage

// ==== design/pvbc_band_search.sv ====
// automatic vco band search: successive approximation over the six band bits
module pvbc_band_search #(
    parameter int SETTLE_CYC = pvbc_pkg::PVBC_SETTLE_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       start,      // one-cycle request for a new search
    input  wire logic       abort,      // pll off or manual mode
    input  wire logic       vco_fast,   // filtered comparator: vco above target
    output logic [5:0]      trial_band, // band applied while searching
    output logic            busy,
    output logic            done        // one-cycle pulse, result in trial_band
);
    localparam int CW = $clog2(SETTLE_CYC + 1);

    pvbc_pkg::pvbc_state_t state_q, state_d;  // search state
    logic [CW-1:0]         cnt_q, cnt_d;      // settle counter
    logic [2:0]            idx_q, idx_d;      // bit under trial
    logic [5:0]            trial_q, trial_d;  // trial band
    logic                  done_q, done_d;

    // next state of the search
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        idx_d   = idx_q;
        trial_d = trial_q;
        done_d  = 1'b0;
        if (start) begin
            // a new request restarts even a running search
            state_d = pvbc_pkg::PVBC_S_SETTLE;
            cnt_d   = '0;
            idx_d   = 3'(pvbc_pkg::PVBC_BAND_W - 1);
            trial_d = pvbc_pkg::PVBC_BAND_MID;
        end else if (abort) begin
            state_d = pvbc_pkg::PVBC_S_IDLE;
        end else begin
            unique case (state_q)
                pvbc_pkg::PVBC_S_IDLE: begin
                    cnt_d = '0;
                end
                pvbc_pkg::PVBC_S_SETTLE: begin
                    if (cnt_q != CW'(SETTLE_CYC - 1)) begin
                        cnt_d = cnt_q + CW'(1);
                    end else begin
                        // loop has settled: keep or drop the trial bit
                        cnt_d = '0;
                        if (vco_fast) begin
                            trial_d[idx_q] = 1'b0;
                        end
                        if (idx_q == 3'h0) begin
                            state_d = pvbc_pkg::PVBC_S_IDLE;
                            done_d  = 1'b1;
                        end else begin
                            idx_d          = idx_q - 3'h1;
                            trial_d[idx_d] = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // search registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_q <= pvbc_pkg::PVBC_S_IDLE;
            cnt_q   <= '0;
            idx_q   <= 3'h0;
            trial_q <= 6'h00;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            idx_q   <= idx_d;
            trial_q <= trial_d;
            done_q  <= done_d;
        end
    end

    assign trial_band = trial_q;
    assign busy       = (state_q == pvbc_pkg::PVBC_S_SETTLE);
    assign done       = done_q;

    a_first_trial: assert property (@(posedge clk_sys) disable iff (!reset_n)
        start |=> (trial_q == pvbc_pkg::PVBC_BAND_MID) && busy)
        else $error("search did not start at mid band");
endmodule

// ==== design/pvbc_top.sv ====
// pll vco band control: pll registers, band selection and clock source control
module pvbc_top #(
    parameter int SETTLE_CYC = pvbc_pkg::PVBC_SETTLE_CYC  // cycles per search step
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic [7:0] reg_addr,           // register offset from the serial port
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,          // one-cycle write strobe
    input  wire logic       reg_read,           // one-cycle read strobe
    output logic      [7:0] reg_rdata,          // valid the cycle after reg_read
    input  wire logic       pll_lock_pin,       // analog lock detect, asynchronous
    input  wire logic       vco_fast_pin,       // analog band comparator, asynchronous
    output logic            pll_enable,         // multiplier powered
    output logic            sample_clock_sel_pll, // 1 multiplier, 0 direct input
    output logic      [5:0] vco_band,
    output logic      [2:0] loop_bandwidth,
    output logic      [4:0] charge_pump_current,
    output logic            cross_point_enable,
    output logic      [4:0] loop_divide_ratio,
    output logic      [3:0] vco_divide_ratio
);
    // loop divider code to ratio: 2, 4, 8 or 16; shared by reset and run time
    function automatic logic [4:0] loop_ratio(input logic [1:0] code);
        loop_ratio = 5'h02 << code;
    endfunction

    // vco divider code to ratio: 1, 2, 4 or 8
    function automatic logic [3:0] vco_ratio(input logic [1:0] code);
        vco_ratio = 4'h1 << code;
    endfunction

    // register file
    logic [7:0] ctrl_q, ctrl_d;        // pll_control
    logic [7:0] loop_q, loop_d;        // pll_loop_config
    logic [7:0] div_q, div_d;          // pll_divider_config
    logic [7:0] rdata_q, rdata_d;
    logic       start_q, start_d;      // search request pulse
    // outputs
    logic [5:0] band_q, band_d;        // band driven to the vco
    logic [5:0] auto_band_q, auto_band_d; // result of the last search
    logic       en_q, en_d;
    logic       sel_q, sel_d;
    logic [2:0] bw_q, bw_d;
    logic [4:0] cp_q, cp_d;
    logic       xpt_q, xpt_d;
    logic [4:0] ldiv_q, ldiv_d;
    logic [3:0] vdiv_q, vdiv_d;
    // pin synchronisers, three stages each
    logic [2:0] lock_s_q, lock_s_d;
    logic [2:0] fast_s_q, fast_s_d;
    logic       lock_q, lock_d;        // filtered lock
    logic       fast_q, fast_d;        // filtered comparator
    // search engine
    logic [5:0] trial_band;
    logic       search_busy;
    logic       search_done;
    logic       search_abort;
    logic       wr_ctrl;

    // only stops the search; one cycle late on abort is harmless
    assign search_abort = !ctrl_q[pvbc_pkg::PVBC_CTRL_EN] || ctrl_q[pvbc_pkg::PVBC_CTRL_MANUAL];

    pvbc_band_search #(
        .SETTLE_CYC (SETTLE_CYC)
    ) u_search (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .start      (start_q),
        .abort      (search_abort),
        .vco_fast   (fast_q),
        .trial_band (trial_band),
        .busy       (search_busy),
        .done       (search_done)
    );

    // register writes, reads and search request
    always_comb begin
        wr_ctrl = reg_write && (reg_addr == pvbc_pkg::PVBC_ADDR_CTRL);
        ctrl_d  = wr_ctrl ? reg_wdata : ctrl_q;
        loop_d  = (reg_write && reg_addr == pvbc_pkg::PVBC_ADDR_LOOP) ? reg_wdata : loop_q;
        div_d   = (reg_write && reg_addr == pvbc_pkg::PVBC_ADDR_DIV) ? reg_wdata : div_q;
        start_d = wr_ctrl && ctrl_q[pvbc_pkg::PVBC_CTRL_EN] && ctrl_q[pvbc_pkg::PVBC_CTRL_MANUAL]
                  && reg_wdata[pvbc_pkg::PVBC_CTRL_EN] && !reg_wdata[pvbc_pkg::PVBC_CTRL_MANUAL];
        rdata_d = rdata_q;
        if (reg_read) begin
            unique case (reg_addr)
                pvbc_pkg::PVBC_ADDR_CTRL: rdata_d = ctrl_q;
                pvbc_pkg::PVBC_ADDR_LOOP: rdata_d = loop_q;
                pvbc_pkg::PVBC_ADDR_DIV:  rdata_d = div_q;
                pvbc_pkg::PVBC_ADDR_STATUS: begin
                    rdata_d = 8'h00;
                    rdata_d[pvbc_pkg::PVBC_ST_LOCK] = lock_q;
                    rdata_d[pvbc_pkg::PVBC_ST_BUSY] = search_busy;
                end
                // unmapped offsets read as zero
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // register file storage
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl_q  <= pvbc_pkg::PVBC_CTRL_RST;
            loop_q  <= pvbc_pkg::PVBC_LOOP_RST;
            div_q   <= pvbc_pkg::PVBC_DIV_RST;
            rdata_q <= 8'h00;
            start_q <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            loop_q  <= loop_d;
            div_q   <= div_d;
            rdata_q <= rdata_d;
            start_q <= start_d;
        end
    end

    // pin filters: a change counts once stages two and three agree
    always_comb begin
        lock_s_d = {lock_s_q[1:0], pll_lock_pin};
        fast_s_d = {fast_s_q[1:0], vco_fast_pin};
        lock_d   = (lock_s_q[1] == lock_s_q[2]) ? lock_s_q[2] : lock_q;
        fast_d   = (fast_s_q[1] == fast_s_q[2]) ? fast_s_q[2] : fast_q;
    end

    // synchroniser registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            lock_s_q <= 3'h0;
            fast_s_q <= 3'h0;
            lock_q   <= 1'b0;
            fast_q   <= 1'b0;
        end else begin
            lock_s_q <= lock_s_d;
            fast_s_q <= fast_s_d;
            lock_q   <= lock_d;
            fast_q   <= fast_d;
        end
    end

    // analog control outputs, all registered so the pll sees clean levels
    always_comb begin
        en_d  = ctrl_q[pvbc_pkg::PVBC_CTRL_EN];
        sel_d = ctrl_q[pvbc_pkg::PVBC_CTRL_EN];
        // result kept until disable or new search
        if (!ctrl_q[pvbc_pkg::PVBC_CTRL_EN]) begin
            auto_band_d = 6'h00;
        end else if (search_done) begin
            auto_band_d = trial_band;
        end else begin
            auto_band_d = auto_band_q;
        end
        // mode picks the six-bit band source
        if (ctrl_q[pvbc_pkg::PVBC_CTRL_MANUAL]) begin
            band_d = ctrl_q[pvbc_pkg::PVBC_BAND_W-1:0];
        end else if (search_busy || search_done) begin
            // the done cycle takes the result directly, else the vco would drop to the stale band for one cycle
            band_d = trial_band;
        end else begin
            band_d = auto_band_q;
        end
        bw_d  = loop_q[pvbc_pkg::PVBC_BW_LSB +: pvbc_pkg::PVBC_BW_W];
        cp_d  = loop_q[pvbc_pkg::PVBC_CP_LSB +: pvbc_pkg::PVBC_CP_W];
        xpt_d = div_q[pvbc_pkg::PVBC_XPT_BIT];
        ldiv_d = loop_ratio(div_q[pvbc_pkg::PVBC_LDIV_LSB +: pvbc_pkg::PVBC_DIV_CODE_W]);
        vdiv_d = vco_ratio(div_q[pvbc_pkg::PVBC_VDIV_LSB +: pvbc_pkg::PVBC_DIV_CODE_W]);
    end

    // output registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            band_q      <= 6'h00;
            auto_band_q <= 6'h00;
            en_q        <= 1'b0;
            sel_q       <= 1'b0;
            // reset outputs match the reset register contents
            bw_q        <= pvbc_pkg::PVBC_LOOP_RST[pvbc_pkg::PVBC_BW_LSB +: pvbc_pkg::PVBC_BW_W];
            cp_q        <= pvbc_pkg::PVBC_LOOP_RST[pvbc_pkg::PVBC_CP_LSB +: pvbc_pkg::PVBC_CP_W];
            xpt_q       <= pvbc_pkg::PVBC_DIV_RST[pvbc_pkg::PVBC_XPT_BIT];
            ldiv_q      <= loop_ratio(pvbc_pkg::PVBC_DIV_RST[pvbc_pkg::PVBC_LDIV_LSB +: pvbc_pkg::PVBC_DIV_CODE_W]);
            vdiv_q      <= vco_ratio(pvbc_pkg::PVBC_DIV_RST[pvbc_pkg::PVBC_VDIV_LSB +: pvbc_pkg::PVBC_DIV_CODE_W]);
        end else begin
            band_q      <= band_d;
            auto_band_q <= auto_band_d;
            en_q        <= en_d;
            sel_q       <= sel_d;
            bw_q        <= bw_d;
            cp_q        <= cp_d;
            xpt_q       <= xpt_d;
            ldiv_q      <= ldiv_d;
            vdiv_q      <= vdiv_d;
        end
    end

    assign reg_rdata            = rdata_q;
    assign pll_enable           = en_q;
    assign sample_clock_sel_pll = sel_q;
    assign vco_band             = band_q;
    assign loop_bandwidth       = bw_q;
    assign charge_pump_current  = cp_q;
    assign cross_point_enable   = xpt_q;
    assign loop_divide_ratio    = ldiv_q;
    assign vco_divide_ratio     = vdiv_q;

    a_search_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_ctrl && ctrl_q[7] && ctrl_q[6] && reg_wdata == 8'h80) |=> start_q ##1 search_busy)
        else $error("automatic request did not start a search");
    a_manual_band: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ctrl_q[6] |=> (vco_band == $past(ctrl_q[5:0])))
        else $error("manual band not driven from control bits");
    a_manual_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ctrl_q[6] && !start_q) ##1 (ctrl_q[6] && !start_q) |=> !search_busy)
        else $error("search running in manual mode");
    a_enable_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ##1 (pll_enable == $past(ctrl_q[7])))
        else $error("pll enable does not follow control bit");
    a_direct_clock: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !ctrl_q[7] |=> !pll_enable && !sample_clock_sel_pll)
        else $error("multiplier on while pll disabled");
    a_band_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ctrl_q[7] && !search_done) |=> $stable(auto_band_q))
        else $error("searched band changed without cause");
    a_band_applied: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!ctrl_q[6] && search_busy) |=> (vco_band == $past(trial_band)))
        else $error("trial band not applied during search");
    a_result_applied: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!ctrl_q[6] && search_done) |=> (vco_band == $past(trial_band)))
        else $error("search result not applied at once");
    a_loop_ratio: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ##1 (loop_divide_ratio == (5'h02 << $past(div_q[1:0]))))
        else $error("loop divide ratio mismatch");
endmodule

// ==== dv/pll_vco_band_control_tb.sv ====
// self-checking bench for the pll vco band control block, driven straight at its register port
`define CHK(got, exp) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end

module pll_vco_band_control_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int SET = 16;  // settle cycles per search step; longer than the 3-4 edge pin filter

    logic       clk_sys;               // 40 mhz system clock
    logic       reset_n;               // synchronous, active low
    logic [7:0] reg_addr;              // register offset
    logic [7:0] reg_wdata;             // write data
    logic       reg_write;             // one-cycle write strobe
    logic       reg_read;              // one-cycle read strobe
    logic [7:0] reg_rdata;             // registered read data
    logic       pll_lock_pin;          // lock detect driven by the bench
    logic       vco_fast_pin;          // comparator modelled by the bench
    logic       pll_enable;
    logic       sample_clock_sel_pll;
    logic [5:0] vco_band;
    logic [2:0] loop_bandwidth;
    logic [4:0] charge_pump_current;
    logic       cross_point_enable;
    logic [4:0] loop_divide_ratio;
    logic [3:0] vco_divide_ratio;
    logic [7:0] rdv;                   // last value read back
    logic [5:0] target;                // band at which the modelled vco meets its target
    logic       search_on;             // comparator active only while a search is expected
    int         fail_count;
    int         n_tests;

    // comparator model: high while the applied band sits above the target band
    assign vco_fast_pin = search_on & (vco_band > target);

    pvbc_top #(
        .SETTLE_CYC (SET)
    ) dut_u (
        .clk_sys              (clk_sys),
        .reset_n              (reset_n),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_write            (reg_write),
        .reg_read             (reg_read),
        .reg_rdata            (reg_rdata),
        .pll_lock_pin         (pll_lock_pin),
        .vco_fast_pin         (vco_fast_pin),
        .pll_enable           (pll_enable),
        .sample_clock_sel_pll (sample_clock_sel_pll),
        .vco_band             (vco_band),
        .loop_bandwidth       (loop_bandwidth),
        .charge_pump_current  (charge_pump_current),
        .cross_point_enable   (cross_point_enable),
        .loop_divide_ratio    (loop_divide_ratio),
        .vco_divide_ratio     (vco_divide_ratio)
    );

    // free-running clock, 25 ns period
    always #12.5 clk_sys = ~clk_sys;

    // one register write; strobe drops after its edge so back-to-back calls stay legal
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #2;
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge clk_sys);
        #2;
        reg_write = 1'b0;
    endtask

    // one register read; data is taken one edge after the read edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        #2;
        reg_addr = a;
        reg_read = 1'b1;
        @(posedge clk_sys);
        #2;
        reg_read = 1'b0;
        @(posedge clk_sys);
        #2;
        rdv = reg_rdata;
    endtask

    // outputs follow a write one edge later; two spare edges for margin
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #2;
    endtask

    // reset values of registers and derived outputs
    task automatic t_reset();
        rd(pvbc_pkg::PVBC_ADDR_CTRL);
        `CHK(rdv, 8'h00)
        rd(pvbc_pkg::PVBC_ADDR_LOOP);
        `CHK(rdv, 8'he7)
        rd(pvbc_pkg::PVBC_ADDR_DIV);
        `CHK(rdv, 8'h00)
        `CHK(loop_bandwidth, 3'h7)
        `CHK(charge_pump_current, 5'h07)
        `CHK(cross_point_enable, 1'b0)
        `CHK(pll_enable, 1'b0)
        `CHK(sample_clock_sel_pll, 1'b0)
        `CHK(loop_divide_ratio, 5'h02)
        `CHK(vco_divide_ratio, 4'h1)
    endtask

    // loop and divider fields reach their outputs, then the recommended values go back
    task automatic t_loop_div();
        wr(pvbc_pkg::PVBC_ADDR_LOOP, 8'h5a);
        wr(pvbc_pkg::PVBC_ADDR_DIV, 8'hd6);
        settle();
        `CHK(loop_bandwidth, 3'h2)
        `CHK(charge_pump_current, 5'h1a)
        `CHK(cross_point_enable, 1'b1)
        `CHK(loop_divide_ratio, 5'h08)
        `CHK(vco_divide_ratio, 4'h2)
        rd(pvbc_pkg::PVBC_ADDR_DIV);
        `CHK(rdv, 8'hd6)
        wr(pvbc_pkg::PVBC_ADDR_LOOP, 8'he7);
        wr(pvbc_pkg::PVBC_ADDR_DIV, 8'hc2);
        settle();
        `CHK(cross_point_enable, 1'b0)
        `CHK(loop_divide_ratio, 5'h08)
        `CHK(vco_divide_ratio, 4'h1)
    endtask

    // every one of the 64 bands in manual mode, then the pll turned off
    task automatic t_manual();
        wr(pvbc_pkg::PVBC_ADDR_CTRL, 8'h15);
        wr(pvbc_pkg::PVBC_ADDR_CTRL, 8'h55);
        settle();
        `CHK(pll_enable, 1'b0)
        wr(pvbc_pkg::PVBC_ADDR_CTRL, 8'hd5);
        settle();
        `CHK(vco_band, 6'h15)
        `CHK(pll_enable, 1'b1)
        for (int b = 0; b < 64; b++) begin
            wr(pvbc_pkg::PVBC_ADDR_CTRL, {2'b11, 6'(b)});
            settle();
            `CHK(vco_band, 6'(b))
        end
        `CHK(pll_enable, 1'b1)
        `CHK(sample_clock_sel_pll, 1'b1)
        wr(pvbc_pkg::PVBC_ADDR_CTRL, 8'h6a);
        settle();
        `CHK(pll_enable, 1'b0)
        `CHK(sample_clock_sel_pll, 1'b0)
    endtask

    // manual-to-automatic starts a search that lands on the target band and holds it
    task automatic t_auto();
        target = 6'h2b;
        search_on = 1'b1;
        wr(pvbc_pkg::PVBC_ADDR_CTRL, 8'hc0);
        wr(pvbc_pkg::PVBC_ADDR_CTRL, 8'h80);
        settle();
        rd(pvbc_pkg::PVBC_ADDR_STATUS);
        `CHK(rdv, 8'h01)
        repeat (6 * SET + 30) @(posedge clk_sys);
        #2;
        `CHK(vco_band, 6'h2b)
        rd(pvbc_pkg::PVBC_ADDR_STATUS);
        `CHK(rdv, 8'h00)
        rd(pvbc_pkg::PVBC_ADDR_CTRL);
        `CHK(rdv, 8'h80)
        // same automatic value again is no manual-to-automatic step, so the band stays
        wr(pvbc_pkg::PVBC_ADDR_CTRL, 8'h80);
        settle();
        `CHK(vco_band, 6'h2b)
        wr(pvbc_pkg::PVBC_ADDR_CTRL, 8'h00);
        wr(pvbc_pkg::PVBC_ADDR_CTRL, 8'h80);
        settle();
        `CHK(vco_band, 6'h00)
    endtask

    // switching to manual in mid-search aborts it and hands the band to the register
    task automatic t_abort();
        wr(pvbc_pkg::PVBC_ADDR_CTRL, 8'hc0);
        wr(pvbc_pkg::PVBC_ADDR_CTRL, 8'h80);
        repeat (10) @(posedge clk_sys);
        wr(pvbc_pkg::PVBC_ADDR_CTRL, 8'hc5);
        settle();
        `CHK(vco_band, 6'h05)
        rd(pvbc_pkg::PVBC_ADDR_STATUS);
        `CHK(rdv, 8'h00)
        search_on = 1'b0;
    endtask

    // unmapped read, ignored write to the status place, lock seen through the filter
    task automatic t_misc();
        rd(8'h30);
        `CHK(rdv, 8'h00)
        wr(pvbc_pkg::PVBC_ADDR_STATUS, 8'hff);
        pll_lock_pin = 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(pvbc_pkg::PVBC_ADDR_STATUS);
        `CHK(rdv, 8'h80)
        pll_lock_pin = 1'b0;
    endtask

    // counts line, verdict, end of run
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // main sequence: reset for two cycles, then every scenario in turn
    initial begin
        clk_sys = 1'b0;
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        pll_lock_pin = 1'b0;
        target = 6'h00;
        search_on = 1'b0;
        rdv = 8'h00;
        fail_count = 0;
        n_tests = 0;
        repeat (2) @(posedge clk_sys);
        #2;
        reset_n = 1'b1;
        t_reset();
        t_loop_div();
        t_manual();
        t_auto();
        t_abort();
        t_misc();
        final_report();
    end

    // watchdog: the whole run needs about 560 cycles, so 100 us is ample
    initial begin
        #100us;
        fail_count++;
        final_report();
    end
endmodule
